//--- verification/gauge_telemetry_word_formatter_bench.sv
// self-checking bench for the gauge telemetry word formatter
// assumes the station model drives link pins and the comparator input
`timescale 1ns/1ps
`include "gtw_params.svh"

module gauge_telemetry_word_formatter_bench
    import gtw_pkg::*;
;
    localparam int unsigned STEP = 50;
    localparam logic [1:0]  OK = `GTW_RESP_OKAY;
    localparam logic [1:0]  ERR = `GTW_RESP_SLVERR;
    logic        aclk = 1'b0;
    logic        aresetn = 1'b0;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        want_up = 1'b0;
    logic        want_dn = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic        shift, demand, frame, cmp_hi, ser;
    logic [2:0]  mux_sel, range_out;
    logic [7:0]  dac_code;
    int          failures = 0;
    int          num_checks = 0;

    always #20 aclk = ~aclk;

    gtw_formatter #(.RANGE_STEP_CYC(STEP)) uut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .shift_in(shift), .demand_in(demand), .frame_in(frame),
        .cmp_hi_in(cmp_hi), .want_up_in(want_up), .want_dn_in(want_dn),
        .serial_out(ser), .mux_sel(mux_sel), .dac_code(dac_code),
        .range_out(range_out)
    );

    gtw_station st (
        .aclk(aclk), .serial_out(ser), .mux_sel(mux_sel),
        .dac_code(dac_code), .shift_in(shift), .demand_in(demand),
        .frame_in(frame), .cmp_hi_in(cmp_hi)
    );

    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic stall();
        failures++;
        $display("CHECK FAILED at %0t: wait 0x0 expected 0x1", $time);
        wrap_up();
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t: got 0x%0h expected 0x%0h",
                     $time, got, exp);
        end
    endtask

    task automatic chkw(input logic [9:0] got, input logic [9:0] exp);
        chk({22'h0, got}, {22'h0, exp});
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                          input logic [1:0] er);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) break;
        end
        if (n == 100) stall();
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic axi_rd(input logic [7:0] a, input logic [31:0] e,
                          input logic [1:0] er);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) break;
        end
        if (n == 100) stall();
        chk(rdata, e);
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
        @(posedge aclk);
    endtask

    task automatic chk_range(input logic [2:0] e);
        chk({29'h0, range_out}, {29'h0, e});
    endtask

    task automatic t_regs();
        axi_rd(`GTW_CTRL_OFS, 32'h0, OK);
        axi_rd(`GTW_STAT_OFS, 32'h0, OK);
        axi_rd(8'h10, 32'h0, ERR);
        axi_wr(8'h10, 32'h7, ERR);
        axi_wr(`GTW_CTRL_OFS, 32'h5, OK);
        axi_rd(`GTW_CTRL_OFS, 32'h5, OK);
        axi_wr(`GTW_CTRL_OFS, 32'h3, OK);
        axi_rd(`GTW_CTRL_OFS, 32'h2, OK);
        axi_rd(`GTW_CMD_OFS, 32'h0, OK);
    endtask

    task automatic t_manual();
        axi_wr(`GTW_CTRL_OFS, 32'h0, OK);
        want_up <= 1'b1;
        repeat (100) @(posedge aclk);
        chk_range(3'h0);
        want_up <= 1'b0;
        repeat (7) axi_wr(`GTW_CMD_OFS, 32'h1, OK);
        repeat (4) @(posedge aclk);
        chk_range(`GTW_RANGE_MAX);
        axi_wr(`GTW_CMD_OFS, 32'h2, OK);
        repeat (4) @(posedge aclk);
        chk_range(3'h5);
    endtask

    // limitation: assumes the step timer idles at zero in manual mode
    task automatic t_auto();
        axi_wr(`GTW_CTRL_OFS, 32'h1, OK);
        want_dn <= 1'b1;
        repeat (10) @(posedge aclk);
        chk_range(3'h4);
        repeat (30) @(posedge aclk);
        chk_range(3'h4);
        repeat (30) @(posedge aclk);
        chk_range(3'h3);
        want_dn <= 1'b0;
        axi_wr(`GTW_CMD_OFS, 32'h1, OK);
        repeat (4) @(posedge aclk);
        chk_range(3'h3);
    endtask

    task automatic t_frames();
        logic [1:0] idx;
        axi_wr(`GTW_CTRL_OFS, 32'h4, OK);
        // the first frame goes unchecked; it advances the housekeeping index to one
        st.run_frame(5);
        idx = 2'h1;
        for (int f = 0; f < 4; f++) begin
            st.run_frame(f == 3 ? 6 : 5);
            chkw(st.words[0], {2'b10, idx, 1'b0, 3'h3, 2'h0});
            chkw(st.words[1], {st.level[0], 2'h1});
            chkw(st.words[2], {st.level[1], 2'h2});
            chkw(st.words[3], {st.level[2], 2'h3});
            chkw(st.words[4], {st.level[3 + idx], idx});
            chk({31'h0, st.idle_hi}, 32'h0);
            idx = idx + 2'h1;
        end
        chkw(st.words[5], 10'h0);
        axi_rd(`GTW_STAT_OFS, {24'h0, 3'h5, idx, 3'h3}, OK);
        axi_rd(`GTW_DATA_OFS, {24'h0, st.level[3]}, OK);
    endtask

    initial begin
        st.level = '{8'hA5, 8'h3C, 8'h81, 8'h11, 8'h22, 8'h44, 8'h88, 8'h00};
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        t_manual();
        t_auto();
        t_frames();
        wrap_up();
    end
endmodule

//--- verification/gtw_station.sv
// station model: frame, demand and shift pulses plus the analog comparator
// assumes it is stepped from the bench right after a rising aclk edge
`timescale 1ns/1ps

module gtw_station
    import gtw_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       serial_out,
    input  wire logic [2:0] mux_sel,
    input  wire logic [7:0] dac_code,
    output logic            shift_in,
    output logic            demand_in,
    output logic            frame_in,
    output logic            cmp_hi_in
);
    logic [7:0] level [8];
    logic [9:0] words [6];
    logic       idle_hi;

    initial begin
        shift_in = 1'b0;
        demand_in = 1'b0;
        frame_in = 1'b0;
        cmp_hi_in = 1'b0;
    end

    // input sits half an lsb above its code, so either convention lands on it
    always @(posedge aclk)
        cmp_hi_in <= {level[mux_sel], 1'b1} > {dac_code, 1'b0};

    // one 320 ns shift period, sampled at its rise
    task automatic shift_bit(output logic b);
        b = serial_out;
        shift_in <= 1'b1;
        repeat (4) @(posedge aclk);
        shift_in <= 1'b0;
        repeat (4) @(posedge aclk);
    endtask

    // shift clock stands still outside frames
    task automatic run_frame(input int slots);
        logic b;
        frame_in <= 1'b1;
        repeat (4) @(posedge aclk);
        frame_in <= 1'b0;
        repeat (4) @(posedge aclk);
        idle_hi = 1'b0;
        for (int s = 0; s < slots; s++) begin
            demand_in <= 1'b1;
            repeat (8) @(posedge aclk);
            for (int i = 9; i >= 0; i--) begin
                shift_bit(b);
                words[s][i] = b;
            end
            demand_in <= 1'b0;
            // gap shifts between slots check that the serial output stays low outside them
            for (int i = 0; i < 9; i++) begin
                shift_bit(b);
                idle_hi = idle_hi | b;
            end
        end
    endtask
endmodule

//--- verilog/gtw_formatter.sv
// gauge telemetry word formatter: five 10-bit words per frame
// assumes station timing pins are asynchronous and run far slower than aclk
// Function
// R1: one analog mux carries all inputs; controller sets its selection order
// R2: converter resolves one bit per step, most significant bit first
// R3: converter compares against the constant regulated reference
// R4: conversion finishes within ten shift pulses, before its word goes out
// R5: word sends eight measurement bits msb first, then two id bits
// R6: shift register holds the assembled word and shifts it in its slot
// R7: ten bits leave one per shift pulse, only in the word's demand period
// R8: each frame carries exactly five words, each with its own demand
// R9: words one to five sit at frame positions 15, 31, 47, 56, 63
// R10: word one packs id, zero, cal, subcom status, auto and range bits
// R11: words two to four carry gauge, gauge temp and package temp
// R12: word five carries one of four housekeeping values and its id
// R13: housekeeping selector counts frames and repeats after four
// R14: in automatic mode range follows the up-down comparator
// R15: multi-step range changes advance one range per ten seconds
// R16: in manual mode range changes only on ground commands
// R17: station supplies shift, data-demand and frame-mark pulses
// R18: word counter pulses on the fifth data-demand of a frame
// R19: range counter spans seven ranges, reported in three bits
// R20: each word position carries its own two-bit id code; word five here sends the housekeeping index instead
// R21: outside its slots serial output idles low and does not shift
`timescale 1ns/1ps
`include "gtw_params.svh"

module gtw_formatter
    import gtw_pkg::*;
#(
    parameter int unsigned RANGE_STEP_CYC = `GTW_STEP_S * `GTW_CLK_HZ
)
(
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    input  wire logic [`GTW_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [`GTW_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    input  wire logic                   shift_in,
    input  wire logic                   demand_in,
    input  wire logic                   frame_in,
    input  wire logic                   cmp_hi_in,
    input  wire logic                   want_up_in,
    input  wire logic                   want_dn_in,
    output logic                        serial_out,
    output logic [2:0]                  mux_sel,
    output logic [7:0]                  dac_code,
    output logic [2:0]                  range_out
);

    localparam logic [27:0] STEP_RELOAD = 28'(RANGE_STEP_CYC - 1);

    // station timing and sense pins: two flops, then edge detect [R17]
    gtw_pins_t pins, sync_a_q, sync_b_q, prev_q, rise, fall;
    assign pins = {shift_in, demand_in, frame_in, cmp_hi_in,
                   want_up_in, want_dn_in};

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync_a_q <= '0;
            sync_b_q <= '0;
            prev_q   <= '0;
        end else begin
            sync_a_q <= pins;
            sync_b_q <= sync_a_q;
            prev_q   <= sync_b_q;
        end
    end

    assign rise = sync_b_q & ~prev_q;
    assign fall = ~sync_b_q & prev_q;

    // mux channel for word n: gauge, gauge temp, package temp, housekeeping
    function automatic logic [2:0] sel_for(input logic [2:0] n,
                                           input logic [1:0] sub);
        case (n)
            3'h2:    sel_for = 3'h0;
            3'h3:    sel_for = 3'h1;
            3'h4:    sel_for = 3'h2;
            default: sel_for = 3'h3 + {1'b0, sub};
        endcase
    endfunction

    // four codes for five slots: word five carries the housekeeping index
    function automatic logic [1:0] id_for(input logic [2:0] n,
                                          input logic [1:0] sub);
        id_for = (n == `GTW_WORDS) ? sub : 2'(n - 3'h1);
    endfunction

    gtw_ctrl_t   ctrl_q, ctrl_d;
    logic [2:0]  range_q, range_d;
    logic [27:0] tmr_q, tmr_d;
    logic        cmd_up_q, cmd_up_d, cmd_dn_q, cmd_dn_d;
    logic [7:0]  conv_res;
    logic        conv_busy;

    // framing group
    logic [2:0] wcnt_q, wcnt_d, wbase, wnext;
    logic [1:0] sub_q, sub_d;
    gtw_shf_t   shf_q, shf_d;
    logic [3:0] bcnt_q, bcnt_d;
    logic [9:0] sreg_q, sreg_d;
    logic       ser_q, ser_d;
    logic [2:0] sel_q, sel_d;
    logic       start_conv, word5_pulse;
    gtw_word_t  w;

    assign wbase       = rise.frame ? 3'h0 : wcnt_q;
    assign wnext       = wbase + 3'h1;
    assign word5_pulse = rise.demand && (wnext == `GTW_WORDS);  // [R18]

    always_comb begin
        wcnt_d     = rise.frame ? 3'h0 : wcnt_q;  // frame mark restarts [R9]
        sub_d      = sub_q;
        shf_d      = shf_q;
        bcnt_d     = bcnt_q;
        sreg_d     = sreg_q;
        sel_d      = sel_q;
        start_conv = 1'b0;
        w          = '0;
        if (rise.demand && wbase < `GTW_WORDS) begin  // [R8]
            wcnt_d = wnext;
            shf_d  = GTW_SHIFT;
            bcnt_d = 4'h0;
            if (wnext == 3'h1) begin
                w.meas = {ctrl_q.zero_mode, ctrl_q.cal_mode, sub_q,
                          ctrl_q.auto_mode, range_q};  // [R10]
            end else begin
                w.meas = conv_res;  // [R11] [R12] [R4]
            end
            w.id   = id_for(wnext, sub_q);  // [R20]
            sreg_d = w;  // [R5] [R6]
            if (word5_pulse) begin
                sub_d = sub_q + 2'h1;  // four-frame cycle [R13]
            end
            if (wnext < `GTW_WORDS) begin
                start_conv = 1'b1;
                sel_d = sel_for(wnext + 3'h1, sub_q);  // [R1]
            end
        end else if (shf_q == GTW_SHIFT) begin
            if (fall.demand) begin
                shf_d = GTW_IDLE;  // slot over, stop even if short [R7]
            end else if (rise.shift) begin
                sreg_d = {sreg_q[8:0], 1'b0};
                bcnt_d = bcnt_q + 4'h1;
                if (bcnt_q == `GTW_LAST_BIT) begin
                    shf_d = GTW_IDLE;  // [R7]
                end
            end
        end
        ser_d = (shf_d == GTW_SHIFT) ? sreg_d[9] : 1'b0;  // [R21]
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wcnt_q <= 3'h0;
            sub_q  <= 2'h0;
            shf_q  <= GTW_IDLE;
            bcnt_q <= 4'h0;
            sreg_q <= 10'h000;
            ser_q  <= 1'b0;
            sel_q  <= 3'h0;
        end else begin
            wcnt_q <= wcnt_d;
            sub_q  <= sub_d;
            shf_q  <= shf_d;
            bcnt_q <= bcnt_d;
            sreg_q <= sreg_d;
            ser_q  <= ser_d;
            sel_q  <= sel_d;
        end
    end

    // steps on shift pulses: eight steps fit inside one ten-pulse period
    gtw_sar u_sar (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .start    (start_conv),
        .step     (rise.shift),
        .cmp_hi   (sync_b_q.cmp_hi),
        .dac_code (dac_code),
        .result   (conv_res),
        .busy     (conv_busy)
    );

    // range group; the long interval keeps relays from chattering
    always_comb begin
        range_d = range_q;
        tmr_d   = (tmr_q != 28'h0) ? tmr_q - 28'h1 : 28'h0;
        if (ctrl_q.auto_mode) begin
            if (tmr_q == 28'h0) begin  // one range per interval [R15]
                if (sync_b_q.want_up && range_q < `GTW_RANGE_MAX) begin
                    range_d = range_q + 3'h1;  // [R14]
                    tmr_d   = STEP_RELOAD;
                end else if (sync_b_q.want_dn && range_q != 3'h0) begin
                    range_d = range_q - 3'h1;  // [R14]
                    tmr_d   = STEP_RELOAD;
                end
            end
        end else if (cmd_up_q && range_q < `GTW_RANGE_MAX) begin
            range_d = range_q + 3'h1;  // [R16] [R19]
        end else if (cmd_dn_q && range_q != 3'h0) begin
            range_d = range_q - 3'h1;  // [R16]
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            range_q <= `GTW_RANGE_RST;
            tmr_q   <= 28'h0;
        end else begin
            range_q <= range_d;
            tmr_q   <= tmr_d;
        end
    end

    // register group: address and data taken in either order
    logic                   aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
    logic [`GTW_ADDR_W-1:0] awaddr_q, awaddr_d, wa;
    logic [31:0]            wdata_q, wdata_d, wd, rdata_q, rdata_d;
    logic [3:0]             wstrb_q, wstrb_d, ws;
    logic                   bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0]             bresp_q, bresp_d, rresp_q, rresp_d;
    logic                   aw_take, w_take;

    assign s_axi_awready = !aw_hold_q && !bvalid_q;
    assign s_axi_wready  = !w_hold_q && !bvalid_q;
    assign s_axi_arready = !rvalid_q;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take  = s_axi_wvalid && s_axi_wready;
    assign wa = aw_hold_q ? awaddr_q : s_axi_awaddr;
    assign wd = w_hold_q ? wdata_q : s_axi_wdata;
    assign ws = w_hold_q ? wstrb_q : s_axi_wstrb;

    always_comb begin
        aw_hold_d = aw_hold_q || aw_take;
        w_hold_d  = w_hold_q || w_take;
        awaddr_d  = aw_take ? s_axi_awaddr : awaddr_q;
        wdata_d   = w_take ? s_axi_wdata : wdata_q;
        wstrb_d   = w_take ? s_axi_wstrb : wstrb_q;
        bvalid_d  = bvalid_q && !s_axi_bready;
        bresp_d   = bresp_q;
        rvalid_d  = rvalid_q && !s_axi_rready;
        rdata_d   = rdata_q;
        rresp_d   = rresp_q;
        ctrl_d    = ctrl_q;
        cmd_up_d  = 1'b0;
        cmd_dn_d  = 1'b0;
        if (aw_hold_d && w_hold_d && !bvalid_q) begin
            aw_hold_d = 1'b0;
            w_hold_d  = 1'b0;
            bvalid_d  = 1'b1;
            bresp_d   = `GTW_RESP_OKAY;
            if (wa == `GTW_CTRL_OFS) begin
                if (ws[0]) begin
                    ctrl_d = wd[`GTW_CTRL_W-1:0];
                    // calibration forces manual ranging
                    if (wd[`GTW_CAL_BIT]) ctrl_d.auto_mode = 1'b0;
                end
            end else if (wa == `GTW_CMD_OFS) begin
                cmd_up_d = ws[0] && wd[`GTW_CMD_UP];
                cmd_dn_d = ws[0] && wd[`GTW_CMD_DN];
            end else begin
                bresp_d = `GTW_RESP_SLVERR;
            end
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d  = `GTW_RESP_OKAY;
            if (s_axi_araddr == `GTW_CTRL_OFS) begin
                rdata_d = {29'h0, ctrl_q};
            end else if (s_axi_araddr == `GTW_CMD_OFS) begin
                rdata_d = 32'h0;
            end else if (s_axi_araddr == `GTW_STAT_OFS) begin
                rdata_d = {22'h0, conv_busy, shf_q == GTW_SHIFT,
                           wcnt_q, sub_q, range_q};
            end else if (s_axi_araddr == `GTW_DATA_OFS) begin
                rdata_d = {24'h0, conv_res};
            end else begin
                rdata_d = 32'h0;
                rresp_d = `GTW_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= '0;
            wdata_q   <= 32'h0;
            wstrb_q   <= 4'h0;
            bvalid_q  <= 1'b0;
            bresp_q   <= `GTW_RESP_OKAY;
            rvalid_q  <= 1'b0;
            rdata_q   <= 32'h0;
            rresp_q   <= `GTW_RESP_OKAY;
            ctrl_q    <= `GTW_CTRL_RST;
            cmd_up_q  <= 1'b0;
            cmd_dn_q  <= 1'b0;
        end else begin
            aw_hold_q <= aw_hold_d;
            w_hold_q  <= w_hold_d;
            awaddr_q  <= awaddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rdata_q   <= rdata_d;
            rresp_q   <= rresp_d;
            ctrl_q    <= ctrl_d;
            cmd_up_q  <= cmd_up_d;
            cmd_dn_q  <= cmd_dn_d;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;
    assign serial_out   = ser_q;
    assign mux_sel      = sel_q;
    assign range_out    = range_q;

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_idle_low: assert property (shf_q == GTW_IDLE |-> !ser_q) // [R21]
        else $error("serial output not idle outside slot");
    a_slot_load: assert property (rise.demand && wbase < `GTW_WORDS
        |=> shf_q == GTW_SHIFT && bcnt_q == 4'h0) // [R7]
        else $error("demand did not open a slot");
    a_ten_bits: assert property (shf_q == GTW_SHIFT && !fall.demand
        && !rise.demand && rise.shift && bcnt_q == `GTW_LAST_BIT
        |=> shf_q == GTW_IDLE) // [R7]
        else $error("slot did not end after ten bits");
    a_msb_first: assert property (rise.demand && wbase == 3'h1
        |=> ser_q == $past(conv_res[7])) // [R5]
        else $error("measurement msb not sent first");
    a_ctrl_word: assert property (rise.demand && wbase == 3'h0
        |=> sreg_q[4:2] == $past(range_q) && sreg_q[1:0] == 2'h0) // [R10]
        else $error("control word layout wrong");
    a_sub_cycle: assert property (word5_pulse
        |=> sub_q == 2'($past(sub_q) + 2'h1)) // [R13]
        else $error("housekeeping index did not advance");
    a_range_max: assert property (range_q <= `GTW_RANGE_MAX) // [R19]
        else $error("range beyond seventh");
    a_manual_hold: assert property (!ctrl_q.auto_mode && !cmd_up_q
        && !cmd_dn_q |=> $stable(range_q)) // [R16]
        else $error("manual range moved without command");
    a_auto_space: assert property (ctrl_q.auto_mode && tmr_q != 28'h0
        |=> $stable(range_q)) // [R15]
        else $error("auto range stepped inside interval");

endmodule

//--- verilog/gtw_params.svh
// constants for the gauge telemetry word formatter
// assumes a 25 MHz bus clock and an AXI4-Lite register port
`ifndef GTW_PARAMS_SVH
`define GTW_PARAMS_SVH

`define GTW_ADDR_W      8
`define GTW_CTRL_OFS    8'h00
`define GTW_CMD_OFS     8'h04
`define GTW_STAT_OFS    8'h08
`define GTW_DATA_OFS    8'h0C

`define GTW_CMD_UP      0
`define GTW_CMD_DN      1
`define GTW_CTRL_W      3
`define GTW_CTRL_RST    3'h0
`define GTW_CAL_BIT     1

`define GTW_WORDS       3'h5
`define GTW_LAST_BIT    4'h9
`define GTW_RANGE_MAX   3'h6
`define GTW_RANGE_RST   3'h0

`define GTW_CLK_HZ      25000000
`define GTW_STEP_S      10

`define GTW_RESP_OKAY   2'h0
`define GTW_RESP_SLVERR 2'h2

`endif

//--- verilog/gtw_pkg.sv
// types shared by the gauge telemetry word formatter
// assumes the constants header is included by the modules
package gtw_pkg;

    typedef struct packed {
        logic [7:0] meas;
        logic [1:0] id;
    } gtw_word_t;

    typedef struct packed {
        logic zero_mode;
        logic cal_mode;
        logic auto_mode;
    } gtw_ctrl_t;

    typedef struct packed {
        logic shift;
        logic demand;
        logic frame;
        logic cmp_hi;
        logic want_up;
        logic want_dn;
    } gtw_pins_t;

    typedef enum logic {
        GTW_IDLE,
        GTW_SHIFT
    } gtw_shf_t;

endpackage

//--- verilog/gtw_sar.sv
// successive approximation sequencer for the gauge formatter
// assumes cmp_hi is already synchronised and step is a one-cycle enable
`timescale 1ns/1ps
`include "gtw_params.svh"

module gtw_sar
    import gtw_pkg::*;
(
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       start,
    input  wire logic       step,
    input  wire logic       cmp_hi,
    output logic [7:0]      dac_code,
    output logic [7:0]      result,
    output logic            busy
);

    logic [7:0] trial_q, trial_d;
    logic [7:0] res_q, res_d;
    logic [2:0] bit_q, bit_d;
    logic       busy_q, busy_d;

    always_comb begin
        trial_d = trial_q;
        res_d   = res_q;
        bit_d   = bit_q;
        busy_d  = busy_q;
        if (start) begin
            trial_d = 8'h80;
            bit_d   = 3'h7;
            busy_d  = 1'b1;
        end else if (step && busy_q) begin
            // comparator sees input against the fixed reference scaled by
            // the trial code; a low answer drops the trial bit [R3] [R2]
            if (!cmp_hi) begin
                trial_d[bit_q] = 1'b0;
            end
            if (bit_q == 3'h0) begin
                res_d  = trial_d;
                busy_d = 1'b0;
            end else begin
                trial_d[bit_q - 3'h1] = 1'b1;
                bit_d = bit_q - 3'h1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trial_q <= 8'h00;
            res_q   <= 8'h00;
            bit_q   <= 3'h0;
            busy_q  <= 1'b0;
        end else begin
            trial_q <= trial_d;
            res_q   <= res_d;
            bit_q   <= bit_d;
            busy_q  <= busy_d;
        end
    end

    assign dac_code = trial_q;
    assign result   = res_q;
    assign busy     = busy_q;

endmodule
